// *** verilog/dadcc_pkg.sv ***
package dadcc_pkg;
  // register byte offsets
  localparam logic [7:0] A_SAR = 8'h00;
  localparam logic [7:0] A_DAR = 8'h04;
  localparam logic [7:0] A_NXT = 8'h08;
  localparam logic [7:0] A_CTL = 8'h0C;
  localparam logic [7:0] A_CFG = 8'h10;
  localparam logic [7:0] A_GTH = 8'h14;
  localparam logic [7:0] A_SCT = 8'h18;
  localparam logic [7:0] A_SWR = 8'h1C;
  localparam logic [7:0] A_STA = 8'h20;
  localparam logic [7:0] A_BLK = 8'h24;
  // control word fields
  localparam int CTL_LEN_LSB = 0;
  localparam int CTL_TRL_LSB = 16;
  localparam int CTL_SAM_LSB = 24;
  localparam int CTL_DAM_LSB = 26;
  localparam int CTL_SFC = 28;
  localparam int CTL_DFC = 29;
  // configuration word fields
  localparam int CFG_EN = 0;
  localparam int CFG_SSW = 1;
  localparam int CFG_DSW = 2;
  localparam int CFG_SIRQ = 3;
  localparam int CFG_DIRQ = 4;
  localparam int CFG_SMEM = 5;
  localparam int CFG_DMEM = 6;
  localparam int CFG_FIFO = 7;
  localparam int CFG_PREF = 8;
  localparam int CFG_LCH = 9;
  localparam int CFG_LBUS = 10;
  localparam int CFG_LSC_LSB = 11;
  localparam int CFG_SMB_LSB = 13;
  localparam int CFG_DMB_LSB = 15;
  localparam int CFG_GEN = 17;
  localparam int CFG_SEN = 18;
  // software request bits
  localparam int SW_SB = 0;
  localparam int SW_SS = 1;
  localparam int SW_DB = 2;
  localparam int SW_DS = 3;
  localparam int SW_SL = 4;
  localparam int SW_DL = 5;
  // values after reset and fixed counts
  localparam logic [15:0] RST_BLOCKS = 16'h0001;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;
  localparam logic [1:0] LLI_LAST = 2'h3;
  // address modes, multi-block modes, lock scopes
  localparam logic [1:0] AM_INC = 2'h0;
  localparam logic [1:0] AM_DEC = 2'h1;
  localparam logic [1:0] MB_RELOAD = 2'h1;
  localparam logic [1:0] MB_CHAIN = 2'h2;
  localparam logic [1:0] LS_XFER = 2'h0;
  localparam logic [1:0] LS_BLOCK = 2'h1;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LLI = 3'b001,
    ST_RUN = 3'b010,
    ST_BEND = 3'b011
  } dadcc_state_e;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } dadcc_sreq_s;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [31:0] adr;
    logic [31:0] dat;
  } dadcc_mreq_s;
endpackage

// *** verilog/dadcc_core.sv ***
`timescale 1ns/1ps
`default_nettype none
module dadcc_core #(
  parameter int DEPTH = 8,
  parameter int MAX_BURST = 4
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register bus, wishbone slave
  input wire dadcc_pkg::dadcc_sreq_s wbs_i,
  output logic [31:0] wbs_dat_o,
  output logic wbs_ack_o,
  // data mover, wishbone master
  output var dadcc_pkg::dadcc_mreq_s wbm_o,
  input wire logic [31:0] wbm_dat_i,
  input wire logic wbm_ack_i,
  output logic chan_lock_o,
  output logic hlock_o,
  // peripheral handshake pins
  input wire logic src_req_i,
  input wire logic src_last_i,
  input wire logic dst_req_i,
  input wire logic dst_last_i,
  output logic src_ack_o,
  output logic dst_ack_o,
  output logic xfer_done_o
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL = (PW + 1)'(DEPTH);
  localparam logic [PW:0] HALF = (PW + 1)'(DEPTH / 2);
  localparam logic [7:0] BMAX = 8'(MAX_BURST - 1);

  typedef struct packed {
    dadcc_pkg::dadcc_state_e st;
    logic [31:0] sar;
    logic [31:0] dar;
    logic [31:0] nxt;
    logic [31:0] ctl;
    logic [31:0] cfg;
    logic [31:0] gth;
    logic [31:0] sct;
    logic [5:0] swr;
    logic [15:0] blocks;
    logic [15:0] blk_left;
    logic [31:0] sv_sar;
    logic [31:0] sv_dar;
    logic [31:0] sv_ctl;
    logic [15:0] src_cnt;
    logic [15:0] g_cnt;
    logic [15:0] s_cnt;
    logic src_done;
    logic dst_done;
    logic str_act;
    logic dtr_act;
    logic s_last;
    logic d_last;
    logic [7:0] str_left;
    logic [7:0] dtr_left;
    logic [1:0] lli_idx;
    logic [7:0] beat;
    dadcc_pkg::dadcc_mreq_s mreq;
    logic [3:0] sy1;
    logic [3:0] sy2;
    logic [3:0] sy3;
    logic [3:0] flt;
    logic [DEPTH-1:0][31:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
    logic s_ack;
    logic [31:0] s_dat;
    logic src_ack;
    logic dst_ack;
    logic done;
  } dadcc_core_s;

  dadcc_core_s r;
  dadcc_core_s n;
  logic [3:0] rise;
  logic [15:0] blen;
  logic [7:0] tlen;
  logic [1:0] sam;
  logic [1:0] dam;
  logic sfc;
  logic dfc;
  logic can_rd;
  logic can_wr;
  logic do_rd;
  logic do_wr;
  logic wr_hit;
  logic [31:0] a1;
  logic scope;

  function automatic logic [31:0] step_addr(input logic [31:0] a, input logic [1:0] m,
                                            input logic [31:0] s);
    if (m == dadcc_pkg::AM_INC) begin
      step_addr = a + s;
    end else if (m == dadcc_pkg::AM_DEC) begin
      step_addr = a - s;
    end else begin
      step_addr = a;
    end
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      o[i*8 +: 8] = sel[i] ? d[i*8 +: 8] : o[i*8 +: 8];
    end
    merge = o;
  endfunction

  always_comb begin
    n = r;
    n.s_ack = 1'b0;
    n.src_ack = 1'b0;
    n.dst_ack = 1'b0;
    n.done = 1'b0;
    a1 = 32'h0000_0000;
    // pins: three stages, a level counts once stages two and three agree
    n.sy1 = {dst_last_i, dst_req_i, src_last_i, src_req_i};
    n.sy2 = r.sy1;
    n.sy3 = r.sy2;
    n.flt = (r.sy2 & r.sy3) | (r.flt & (r.sy2 ^ r.sy3));
    rise = n.flt & ~r.flt;
    blen = (r.ctl[dadcc_pkg::CTL_LEN_LSB +: 16] == 16'h0000) ? 16'h0001
         : r.ctl[dadcc_pkg::CTL_LEN_LSB +: 16];
    tlen = (r.ctl[dadcc_pkg::CTL_TRL_LSB +: 8] == 8'h00) ? 8'h01
         : r.ctl[dadcc_pkg::CTL_TRL_LSB +: 8];
    sam = r.ctl[dadcc_pkg::CTL_SAM_LSB +: 2];
    dam = r.ctl[dadcc_pkg::CTL_DAM_LSB +: 2];
    sfc = r.ctl[dadcc_pkg::CTL_SFC];
    dfc = r.ctl[dadcc_pkg::CTL_DFC];

    // register slave: ack one cycle after the request, write lands on the ack edge
    wr_hit = wbs_i.cyc & wbs_i.stb & wbs_i.we & r.s_ack;
    n.s_ack = wbs_i.cyc & wbs_i.stb & ~r.s_ack;
    case (wbs_i.adr)
      dadcc_pkg::A_SAR: n.s_dat = r.sar;
      dadcc_pkg::A_DAR: n.s_dat = r.dar;
      dadcc_pkg::A_NXT: n.s_dat = r.nxt;
      dadcc_pkg::A_CTL: n.s_dat = r.ctl;
      dadcc_pkg::A_CFG: n.s_dat = r.cfg;
      dadcc_pkg::A_GTH: n.s_dat = r.gth;
      dadcc_pkg::A_SCT: n.s_dat = r.sct;
      dadcc_pkg::A_SWR: n.s_dat = {26'h0, r.swr};
      dadcc_pkg::A_STA: n.s_dat = {19'h0, 7'(r.cnt), r.st, r.dst_done, r.src_done,
                                   (r.st != dadcc_pkg::ST_IDLE)};
      dadcc_pkg::A_BLK: n.s_dat = {16'h0, r.blocks};
      default: n.s_dat = 32'h0000_0000;
    endcase
    if (wr_hit) begin
      case (wbs_i.adr)
        dadcc_pkg::A_SAR: n.sar = merge(r.sar, wbs_i.dat, wbs_i.sel);
        dadcc_pkg::A_DAR: n.dar = merge(r.dar, wbs_i.dat, wbs_i.sel);
        dadcc_pkg::A_NXT: n.nxt = merge(r.nxt, wbs_i.dat, wbs_i.sel);
        dadcc_pkg::A_CTL: n.ctl = merge(r.ctl, wbs_i.dat, wbs_i.sel);
        dadcc_pkg::A_CFG: n.cfg = merge(r.cfg, wbs_i.dat, wbs_i.sel);
        dadcc_pkg::A_GTH: n.gth = merge(r.gth, wbs_i.dat, wbs_i.sel);
        dadcc_pkg::A_SCT: n.sct = merge(r.sct, wbs_i.dat, wbs_i.sel);
        dadcc_pkg::A_BLK: n.blocks = 16'(merge({16'h0, r.blocks}, wbs_i.dat, wbs_i.sel));
        default: n.s_dat = n.s_dat;
      endcase
    end

    // a memory side is always ready; fifo mode waits for half full thresholds
    can_rd = (r.st == dadcc_pkg::ST_RUN) && !r.src_done && (r.cnt < FULL)
           && (!r.cfg[dadcc_pkg::CFG_FIFO] || r.cnt < HALF)
           && (r.cfg[dadcc_pkg::CFG_SMEM] || r.str_act)
           && !(dfc && r.cfg[dadcc_pkg::CFG_PREF] && !r.dtr_act) && !r.dst_done;
    can_wr = (r.st == dadcc_pkg::ST_RUN) && (r.cnt != '0) && !r.dst_done
           && (!r.cfg[dadcc_pkg::CFG_FIFO] || r.cnt >= HALF || r.src_done)
           && (r.cfg[dadcc_pkg::CFG_DMEM] || r.dtr_act);
    // single master port: alternate read and write, keep direction inside a held cycle
    do_wr = can_wr && (!can_rd || (r.mreq.cyc ? r.mreq.we : !r.mreq.we));
    do_rd = can_rd && !do_wr;

    case (r.st)
      dadcc_pkg::ST_IDLE: begin
        if (r.cfg[dadcc_pkg::CFG_EN]) begin
          n.sv_sar = r.sar;
          n.sv_dar = r.dar;
          n.sv_ctl = r.ctl;
          n.blk_left = (r.blocks == 16'h0000) ? 16'h0001 : r.blocks;
          n.src_cnt = 16'h0000;
          n.g_cnt = 16'h0000;
          n.s_cnt = 16'h0000;
          n.lli_idx = 2'h0;
          n.cnt = '0;
          n.wp = '0;
          n.rp = '0;
          n.st = (r.cfg[dadcc_pkg::CFG_SMB_LSB +: 2] == dadcc_pkg::MB_CHAIN
                  || r.cfg[dadcc_pkg::CFG_DMB_LSB +: 2] == dadcc_pkg::MB_CHAIN)
                 ? dadcc_pkg::ST_LLI : dadcc_pkg::ST_RUN;
        end
      end
      dadcc_pkg::ST_LLI: begin
        // descriptor words: source, destination, next pointer, control
        if (!r.mreq.stb) begin
          n.mreq = '{cyc: 1'b1, stb: 1'b1, we: 1'b0,
                     adr: r.nxt + {28'h0, r.lli_idx, 2'b00}, dat: 32'h0000_0000};
        end else if (wbm_ack_i) begin
          n.mreq.stb = 1'b0;
          n.lli_idx = r.lli_idx + 2'h1;
          case (r.lli_idx)
            2'h0: if (r.cfg[dadcc_pkg::CFG_SMB_LSB +: 2] == dadcc_pkg::MB_CHAIN) n.sar = wbm_dat_i;
            2'h1: if (r.cfg[dadcc_pkg::CFG_DMB_LSB +: 2] == dadcc_pkg::MB_CHAIN) n.dar = wbm_dat_i;
            2'h2: n.nxt = wbm_dat_i;
            default: n.ctl = wbm_dat_i;
          endcase
          if (r.lli_idx == dadcc_pkg::LLI_LAST) begin
            n.mreq.cyc = 1'b0;
            n.st = dadcc_pkg::ST_RUN;
          end
        end
      end
      dadcc_pkg::ST_RUN: begin
        // source transaction start
        if (!r.cfg[dadcc_pkg::CFG_SMEM] && !r.str_act && !r.src_done) begin
          if (r.cfg[dadcc_pkg::CFG_SSW]) begin
            if (r.swr[dadcc_pkg::SW_SS]) begin
              n.str_act = 1'b1;
              n.str_left = r.swr[dadcc_pkg::SW_SB] ? tlen : 8'h01;
              n.s_last = sfc && r.swr[dadcc_pkg::SW_SL];
            end
          end else if (rise[0]) begin
            n.str_act = 1'b1;
            n.str_left = tlen;
            n.s_last = sfc && r.flt[1] && !r.cfg[dadcc_pkg::CFG_SIRQ];
          end
        end
        // destination transaction start
        if (!r.cfg[dadcc_pkg::CFG_DMEM] && !r.dtr_act && !r.dst_done) begin
          if (r.cfg[dadcc_pkg::CFG_DSW]) begin
            if (r.swr[dadcc_pkg::SW_DS]) begin
              n.dtr_act = 1'b1;
              n.dtr_left = r.swr[dadcc_pkg::SW_DB] ? tlen : 8'h01;
              n.d_last = dfc && r.swr[dadcc_pkg::SW_DL];
            end
          end else if (rise[2]) begin
            n.dtr_act = 1'b1;
            n.dtr_left = tlen;
            n.d_last = dfc && r.flt[3] && !r.cfg[dadcc_pkg::CFG_DIRQ];
          end
        end
        if (r.mreq.stb) begin
          if (wbm_ack_i) begin
            n.mreq.stb = 1'b0;
            // hold the cycle up to the maximum bus burst so the bus is not re-arbitrated
            n.mreq.cyc = (r.beat < BMAX);
            n.beat = (r.beat < BMAX) ? r.beat + 8'h01 : 8'h00;
            if (!r.mreq.we) begin
              n.mem[r.wp] = wbm_dat_i;
              n.wp = (r.wp == PW'(DEPTH - 1)) ? '0 : r.wp + PW'(1);
              n.cnt = r.cnt + (PW + 1)'(1);
              n.src_cnt = r.src_cnt + 16'h0001;
              a1 = step_addr(r.sar, sam, dadcc_pkg::WORD_STEP);
              n.g_cnt = r.g_cnt + 16'h0001;
              if (r.cfg[dadcc_pkg::CFG_GEN] && n.g_cnt == r.gth[15:0]) begin
                a1 = step_addr(a1, sam, {16'h0, r.gth[31:16]});
                n.g_cnt = 16'h0000;
              end
              n.sar = a1;
              if (!sfc && !dfc && n.src_cnt == blen) begin
                n.src_done = 1'b1;
              end
              if (r.str_act && (r.str_left == 8'h01 || n.src_done)) begin
                n.str_act = 1'b0;
                n.src_ack = 1'b1;
                n.swr[dadcc_pkg::SW_SL:0] = '0;
                n.swr[dadcc_pkg::SW_SS] = 1'b0;
                n.swr[dadcc_pkg::SW_SL] = 1'b0;
                n.src_done = n.src_done || r.s_last;
              end else begin
                n.str_left = r.str_left - 8'h01;
              end
            end else begin
              n.rp = (r.rp == PW'(DEPTH - 1)) ? '0 : r.rp + PW'(1);
              n.cnt = r.cnt - (PW + 1)'(1);
              a1 = step_addr(r.dar, dam, dadcc_pkg::WORD_STEP);
              n.s_cnt = r.s_cnt + 16'h0001;
              if (r.cfg[dadcc_pkg::CFG_SEN] && n.s_cnt == r.sct[15:0]) begin
                a1 = step_addr(a1, dam, {16'h0, r.sct[31:16]});
                n.s_cnt = 16'h0000;
              end
              n.dar = a1;
              if (r.dtr_act) begin
                if (r.dtr_left == 8'h01) begin
                  n.dtr_act = 1'b0;
                  n.dst_ack = 1'b1;
                  n.swr[dadcc_pkg::SW_DS:dadcc_pkg::SW_DB] = 2'b00;
                  n.swr[dadcc_pkg::SW_DL] = 1'b0;
                  n.dst_done = r.d_last;
                end else begin
                  n.dtr_left = r.dtr_left - 8'h01;
                end
              end
            end
          end
        end else if (do_rd || do_wr) begin
          if (r.mreq.cyc && (r.mreq.we != do_wr)) begin
            n.beat = 8'h00;
          end
          n.mreq = '{cyc: 1'b1, stb: 1'b1, we: do_wr, adr: do_wr ? r.dar : r.sar,
                     dat: r.mem[r.rp]};
        end else begin
          n.mreq.cyc = 1'b0;
          n.beat = 8'h00;
          if ((r.src_done && r.cnt == '0 && !dfc) || r.dst_done) begin
            n.st = dadcc_pkg::ST_BEND;
          end
        end
      end
      dadcc_pkg::ST_BEND: begin
        // leftover fifo data is dropped when the destination ends the block early
        n.cnt = '0;
        n.wp = '0;
        n.rp = '0;
        n.src_done = 1'b0;
        n.dst_done = 1'b0;
        n.str_act = 1'b0;
        n.dtr_act = 1'b0;
        n.src_cnt = 16'h0000;
        n.lli_idx = 2'h0;
        if (r.blk_left == 16'h0001) begin
          n.cfg[dadcc_pkg::CFG_EN] = 1'b0;
          n.done = 1'b1;
          n.st = dadcc_pkg::ST_IDLE;
        end else begin
          n.blk_left = r.blk_left - 16'h0001;
          // contiguous mode leaves the address where the block ended
          if (r.cfg[dadcc_pkg::CFG_SMB_LSB +: 2] == dadcc_pkg::MB_RELOAD) begin
            n.sar = r.sv_sar;
            n.ctl = r.sv_ctl;
          end
          if (r.cfg[dadcc_pkg::CFG_DMB_LSB +: 2] == dadcc_pkg::MB_RELOAD) begin
            n.dar = r.sv_dar;
            n.ctl = r.sv_ctl;
          end
          n.st = (r.cfg[dadcc_pkg::CFG_SMB_LSB +: 2] == dadcc_pkg::MB_CHAIN
                  || r.cfg[dadcc_pkg::CFG_DMB_LSB +: 2] == dadcc_pkg::MB_CHAIN)
                 ? dadcc_pkg::ST_LLI : dadcc_pkg::ST_RUN;
        end
      end
      default: n.st = dadcc_pkg::ST_IDLE;
    endcase

    // software disable aborts once no bus access is outstanding
    if (!r.cfg[dadcc_pkg::CFG_EN] && r.st != dadcc_pkg::ST_IDLE && !r.mreq.stb) begin
      n.st = dadcc_pkg::ST_IDLE;
      n.mreq.cyc = 1'b0;
      n.str_act = 1'b0;
      n.dtr_act = 1'b0;
      n.src_done = 1'b0;
      n.dst_done = 1'b0;
    end
    // request bits written 1 by software win over a hardware clear in the same cycle
    if (wr_hit && wbs_i.adr == dadcc_pkg::A_SWR && wbs_i.sel[0]) begin
      n.swr = n.swr | wbs_i.dat[5:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
      r.blocks <= dadcc_pkg::RST_BLOCKS;
    end else begin
      r <= n;
    end
  end

  // lock scope: whole transfer, current block, or an open transaction
  always_comb begin
    case (r.cfg[dadcc_pkg::CFG_LSC_LSB +: 2])
      dadcc_pkg::LS_XFER: scope = (r.st != dadcc_pkg::ST_IDLE);
      dadcc_pkg::LS_BLOCK: scope = (r.st == dadcc_pkg::ST_RUN);
      default: scope = r.str_act || r.dtr_act || r.mreq.cyc;
    endcase
  end

  assign hlock_o = r.cfg[dadcc_pkg::CFG_LBUS] && scope;
  assign chan_lock_o = (r.cfg[dadcc_pkg::CFG_LCH] || r.cfg[dadcc_pkg::CFG_LBUS]) && scope;
  assign wbm_o = r.mreq;
  assign wbs_dat_o = r.s_dat;
  assign wbs_ack_o = r.s_ack;
  assign src_ack_o = r.src_ack;
  assign dst_ack_o = r.dst_ack;
  assign xfer_done_o = r.done;
endmodule
`default_nettype wire

// *** verif/dadcc_core_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module dadcc_core_props (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register bus
  input wire dadcc_pkg::dadcc_sreq_s wbs_i,
  input wire logic wbs_ack_o,
  // data mover
  input wire dadcc_pkg::dadcc_mreq_s wbm_o,
  input wire logic wbm_ack_i,
  input wire logic chan_lock_o,
  input wire logic hlock_o,
  // handshake and status
  input wire logic src_ack_o,
  input wire logic xfer_done_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_sreq;
    wbs_i.cyc && wbs_i.stb && !wbs_ack_o;
  endsequence
  sequence s_mwait;
    wbm_o.stb && !wbm_ack_i;
  endsequence

  property p_sack;
    s_sreq |=> wbs_ack_o;
  endproperty
  a_sack: assert property (p_sack) else $error("slave ack late");
  property p_sack_pulse;
    wbs_ack_o |=> !wbs_ack_o;
  endproperty
  a_sack_pulse: assert property (p_sack_pulse) else $error("slave ack too long");
  // address, direction and data must not move while the access waits
  property p_mhold;
    s_mwait |=> wbm_o.stb && $stable(wbm_o.adr) && $stable(wbm_o.we) && $stable(wbm_o.dat);
  endproperty
  a_mhold: assert property (p_mhold) else $error("master request moved");
  property p_mgap;
    wbm_o.stb && wbm_ack_i |=> !wbm_o.stb;
  endproperty
  a_mgap: assert property (p_mgap) else $error("strobe right after ack");
  property p_mcyc;
    wbm_o.stb |-> wbm_o.cyc;
  endproperty
  a_mcyc: assert property (p_mcyc) else $error("strobe without cycle");
  property p_lock;
    hlock_o |-> chan_lock_o;
  endproperty
  a_lock: assert property (p_lock) else $error("bus lock without channel lock");
  property p_src_ack;
    src_ack_o |=> !src_ack_o;
  endproperty
  a_src_ack: assert property (p_src_ack) else $error("source ack too long");
  property p_src_ack_cause;
    src_ack_o |-> $past(wbm_ack_i);
  endproperty
  a_src_ack_cause: assert property (p_src_ack_cause) else $error("ack not after transfer");
  // a finished channel stays quiet for the two cycles after the done pulse
  property p_done;
    xfer_done_o |=> (!xfer_done_o && !wbm_o.stb) [*2];
  endproperty
  a_done: assert property (p_done) else $error("activity after done");
endmodule
bind dadcc_core dadcc_core_props u_props (
  .clk_i(clk_i), .rst_i(rst_i), .wbs_i(wbs_i), .wbs_ack_o(wbs_ack_o), .wbm_o(wbm_o),
  .wbm_ack_i(wbm_ack_i), .chan_lock_o(chan_lock_o), .hlock_o(hlock_o),
  .src_ack_o(src_ack_o), .xfer_done_o(xfer_done_o)
);
`default_nettype wire

// *** verif/dadcc_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module dadcc_mem_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus from the channel
  input wire dadcc_pkg::dadcc_mreq_s req_i,
  input wire logic [3:0] wait_i,
  output logic [31:0] dat_o,
  output logic ack_o
);
  logic [31:0] mem [64];
  logic [3:0] wcnt_r;
  int rd_cnt;
  int wr_cnt;
  initial begin
    for (int i = 0; i < 64; i++) mem[i] = 32'h5A00_0000 | i;
    dat_o = 32'h0;
    ack_o = 1'b0;
    wcnt_r = 4'h0;
    rd_cnt = 0;
    wr_cnt = 0;
  end
  // wait states stop at 15, inside what a memory endpoint may insert
  // data toggles whenever not acked so stale values never look valid
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      wcnt_r <= 4'h0;
    end else if (ack_o) begin
      ack_o <= 1'b0;
      wcnt_r <= 4'h0;
      dat_o <= ~dat_o;
      if (req_i.we) begin
        mem[req_i.adr[7:2]] <= req_i.dat;
        wr_cnt <= wr_cnt + 1;
      end
    end else if (req_i.cyc && req_i.stb && wcnt_r == wait_i) begin
      ack_o <= 1'b1;
      if (!req_i.we) begin
        dat_o <= mem[req_i.adr[7:2]];
        rd_cnt <= rd_cnt + 1;
      end
    end else begin
      if (req_i.cyc && req_i.stb) wcnt_r <= wcnt_r + 4'h1;
      dat_o <= ~dat_o;
    end
  end
endmodule
`default_nettype wire

// *** verif/tb_dual_access_dma_channel_core.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_dual_access_dma_channel_core;
  localparam logic [31:0] EN = 32'h1 << dadcc_pkg::CFG_EN;
  localparam logic [31:0] MEMS = (32'h1 << dadcc_pkg::CFG_SMEM) | (32'h1 << dadcc_pkg::CFG_DMEM);
  localparam logic [31:0] DMEM = 32'h1 << dadcc_pkg::CFG_DMEM;
  localparam logic [31:0] LOCKS = (32'h1 << dadcc_pkg::CFG_LCH) | (32'h1 << dadcc_pkg::CFG_LBUS);
  logic clk_i;
  logic rst_i;
  dadcc_pkg::dadcc_sreq_s wbs;
  dadcc_pkg::dadcc_mreq_s wbm;
  logic [31:0] wbs_dat, wbm_dat, q;
  logic wbs_ack, wbm_ack, src_req, src_ack, done_p, lock_c, lock_h;
  logic [3:0] wait_n;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;

  dadcc_core dut (.clk_i(clk_i), .rst_i(rst_i), .wbs_i(wbs), .wbs_dat_o(wbs_dat),
    .wbs_ack_o(wbs_ack), .wbm_o(wbm), .wbm_dat_i(wbm_dat), .wbm_ack_i(wbm_ack),
    .chan_lock_o(lock_c), .hlock_o(lock_h), .src_req_i(src_req), .src_last_i(1'b0),
    .dst_req_i(1'b0),
    .dst_last_i(1'b0), .src_ack_o(src_ack), .dst_ack_o(), .xfer_done_o(done_p));
  dadcc_mem_model m (.clk_i(clk_i), .rst_i(rst_i), .req_i(wbm), .wait_i(wait_n),
    .dat_o(wbm_dat), .ack_o(wbm_ack));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // the whole run needs a few hundred cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      test_done();
    end
  end

  task test_done;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wbs <= {2'b11, we, 4'hF, a, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wbs_ack !== 1'b1 && n < 40);
    q = wbs_dat;
    wbs.cyc <= 1'b0;
    wbs.stb <= 1'b0;
    if (wbs_ack !== 1'b1) begin
      mismatches++;
      test_done();
    end
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    wb(1'b0, a, 32'h0);
    chk(q, exp, what);
  endtask
  task setup(input logic [31:0] sar, dar, ctl, blk, cfg);
    wb(1'b1, dadcc_pkg::A_SAR, sar);
    wb(1'b1, dadcc_pkg::A_DAR, dar);
    wb(1'b1, dadcc_pkg::A_CTL, ctl);
    wb(1'b1, dadcc_pkg::A_BLK, blk);
    wb(1'b1, dadcc_pkg::A_CFG, cfg);
  endtask
  // pulses are looked at just after each edge, in the cycle they stand
  task run(input int n, output int dn, output int sa);
    dn = 0;
    sa = 0;
    for (int i = 0; i < n && dn == 0; i++) begin
      @(posedge clk_i);
      #1;
      dn += (done_p === 1'b1);
      sa += (src_ack === 1'b1);
    end
  endtask

  task t_regs;
    rd_chk(dadcc_pkg::A_BLK, {16'h0, dadcc_pkg::RST_BLOCKS}, "blocks reset");
    rd_chk(dadcc_pkg::A_CFG, 32'h0, "config reset");
    wb(1'b1, 8'h3C, 32'hFFFF_FFFF);
    rd_chk(8'h3C, 32'h0, "unmapped");
    wb(1'b1, dadcc_pkg::A_NXT, 32'h0000_1230);
    rd_chk(dadcc_pkg::A_NXT, 32'h0000_1230, "pointer");
  endtask
  task t_m2m;
    int r0, w0, dn, sa;
    r0 = m.rd_cnt;
    w0 = m.wr_cnt;
    wait_n <= 4'hF;
    setup(32'h0, 32'h80, 32'h4, 32'h1, EN | MEMS | LOCKS);
    @(posedge clk_i);
    #1;
    chk({30'h0, lock_c, lock_h}, 32'h3, "locks held");
    run(2000, dn, sa);
    chk(dn, 32'h1, "done");
    chk(m.rd_cnt - r0, 32'h4, "reads");
    chk(m.wr_cnt - w0, 32'h4, "writes");
    for (int i = 0; i < 4; i++) chk(m.mem[32 + i], 32'h5A00_0000 | i, "copy");
    wb(1'b0, dadcc_pkg::A_CFG, 32'h0);
    chk({31'h0, q[dadcc_pkg::CFG_EN]}, 32'h0, "enable cleared");
    chk({30'h0, lock_c, lock_h}, 32'h0, "locks released");
  endtask
  task t_contig;
    int dn, sa;
    wait_n <= 4'h0;
    setup(32'h10, 32'hA0, 32'h2, 32'h2, EN | MEMS);
    run(1000, dn, sa);
    chk(dn, 32'h1, "two blocks done");
    for (int i = 0; i < 4; i++) chk(m.mem[40 + i], 32'h5A00_0004 + i, "contig");
  endtask
  task t_sw;
    int r0, dn, sa;
    r0 = m.rd_cnt;
    setup(32'h20, 32'hC0, 32'h0002_0002, 32'h1, EN | DMEM | (32'h1 << dadcc_pkg::CFG_SSW));
    wb(1'b1, dadcc_pkg::A_SWR, 32'h1 << dadcc_pkg::SW_SB);
    run(40, dn, sa);
    chk(m.rd_cnt - r0, 32'h0, "burst bit alone");
    wb(1'b1, dadcc_pkg::A_SWR, 32'h1 << dadcc_pkg::SW_SS);
    run(400, dn, sa);
    chk(sa, 32'h1, "software ack");
    chk(dn, 32'h1, "software done");
    rd_chk(dadcc_pkg::A_SWR, 32'h0, "request bits cleared");
    chk(m.mem[49], 32'h5A00_0009, "burst data");
  endtask
  task t_hw;
    int r0, dn, sa;
    r0 = m.rd_cnt;
    setup(32'h30, 32'hD0, 32'h0001_0002, 32'h1, EN | DMEM);
    src_req <= 1'b1;
    run(60, dn, sa);
    chk(sa, 32'h1, "one transaction per edge");
    chk(m.rd_cnt - r0, 32'h1, "single item");
    src_req <= 1'b0;
    run(8, dn, sa);
    src_req <= 1'b1;
    run(200, dn, sa);
    chk(dn, 32'h1, "second edge served");
    chk(m.mem[53], 32'h5A00_000D, "second item");
    src_req <= 1'b0;
  endtask

  initial begin
    rst_i = 1'b1;
    wbs = '0;
    src_req = 1'b0;
    wait_n = 4'h0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_m2m();
    t_contig();
    t_sw();
    t_hw();
    test_done();
  end
endmodule
`default_nettype wire
